// ==== verilog/wit_timer.sv ====
`timescale 1ns/1ps
// Functional notes
// - byte reads at three fixed addresses
// - watchdog overflow sets flag, drives output low
// - output low 132 or 130 states
// - reset enabled: internal reset with output
// - internal reset lasts 518 states
// - pin reset wins, clears watchdog flag
// - no chip reset, still clear counter/control
// - interval overflow sets flag, requests interrupt
// - counter write beats coinciding increment
// - output low: writes and flag reads ignored
// - keyed word write selects counter or control
// - reset register keys: clear flag or bits
// - reset type zero power-on, one manual
// - overflow is FF to 00; halt clears
module wit_timer #(
    parameter int PRE_W = 17 // prescaler width
) (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 external_reset_pin_n,
    input  wire wit_pkg::wit_bus_req_t bus_req,
    output logic [7:0]                bus_rdata,
    output logic                      overflow_out_n,
    output logic                      interval_irq,
    output wit_pkg::wit_int_rst_t     int_reset
);
    import wit_pkg::*;

    // ======================================================
    // state
    // ======================================================
    logic       pin_s1_r, pin_s2_r; // pin synchroniser
    logic [7:0] count_r;            // timer_counter_value
    logic       ovf_r;              // interval_overflow_flag
    logic       mode_r;             // timer_mode_select
    logic       run_r;              // count_run
    logic [2:0] cks_r;              // clock_divider_select
    logic       wdflag_r;           // watchdog_overflow_flag
    logic       rgen_r;             // reset_gen_enable
    logic       rtype_r;            // reset_type_select
    logic       ovf_arm_r;          // interval flag seen as one
    logic       wdflag_arm_r;       // watchdog flag seen as one
    logic       out_low_r;          // overflow output asserted
    logic [7:0] out_cnt_r;          // remaining low states minus one
    logic       out_rgen_r;         // reset enable at the overflow
    logic       irst_r;             // internal reset active
    logic       irst_man_r;         // internal reset type
    logic [9:0] irst_cnt_r;         // remaining reset states minus one
    logic [7:0] rdata_r;            // read data
    logic [7:0] count_nxt;          // next counter value

    // ======================================================
    // decode
    // ======================================================
    logic       pin_rst;  // synchronised pin reset
    logic       hard_rst; // full reset of every register but the pin synchroniser
    logic       tick;     // prescaler count pulse
    logic [7:0] key;      // upper byte of a word write
    logic [7:0] wdat;     // lower byte of a word write
    logic       wr_ok;    // writes allowed (output high)
    logic       wr_cnt;   // counter write
    logic       wr_ctl;   // control register write
    logic       wr_wclr;  // watchdog flag clear write
    logic       wr_rbits; // reset enable/type write
    logic       rd_ctl;   // control register read
    logic       rd_rst;   // reset register read
    logic       wrap;     // counter wraps this cycle
    logic       wd_evt;   // watchdog overflow
    logic       it_evt;   // interval overflow
    logic       ovf_clr;  // interval flag clear accepted
    logic       wd_clr;   // watchdog flag clear accepted
    logic [7:0] ctl_view; // control register as read
    logic [7:0] rst_view; // reset register as read

    assign pin_rst  = ~pin_s2_r;
    assign hard_rst = sys_rst | pin_rst;
    assign key      = bus_req.wdata[15:8];
    assign wdat     = bus_req.wdata[7:0];
    assign wr_ok    = bus_req.wr & ~out_low_r;
    assign wr_cnt   = wr_ok & (bus_req.addr == ADDR_CTRL_WR) & (key == KEY_CNT);
    assign wr_ctl   = wr_ok & (bus_req.addr == ADDR_CTRL_WR) & (key == KEY_CTRL);
    assign wr_wclr  = wr_ok & (bus_req.addr == ADDR_RST_WR) & (key == KEY_CTRL)
                      & (wdat == WD_CLR_DATA);
    assign wr_rbits = wr_ok & (bus_req.addr == ADDR_RST_WR) & (key == KEY_CNT);
    assign rd_ctl   = bus_req.rd & (bus_req.addr == ADDR_CTRL_RD);
    assign rd_rst   = bus_req.rd & (bus_req.addr == ADDR_RST_RD);
    // a write in the same cycle as a tick takes the counter
    assign wrap     = run_r & tick & (count_r == CNT_MAX) & ~wr_cnt;
    assign wd_evt   = wrap & mode_r;
    assign it_evt   = wrap & ~mode_r;
    assign ovf_clr  = wr_ctl & ovf_arm_r & ~wdat[CTL_OVF_BIT];
    assign wd_clr   = wr_wclr & wdflag_arm_r;
    assign ctl_view = {ovf_r, mode_r, run_r, 2'b00, cks_r} | CTL_RESERVED;
    assign rst_view = {wdflag_r, rgen_r, rtype_r, 5'b00000} | RST_RESERVED;

    // ======================================================
    // counter next value
    // ======================================================
    always_comb begin
        count_nxt = count_r;
        if (!run_r || wd_evt) begin
            count_nxt = CNT_ZERO;
        end else if (wr_cnt) begin
            count_nxt = wdat;
        end else if (tick) begin
            count_nxt = count_r + 8'h01;
        end
    end

    // ======================================================
    // prescaler, held clear while halted
    // ======================================================
    wit_prescaler #(
        .PRE_W (PRE_W)
    ) u_pre (
        .ref_clk (ref_clk),
        .clr     (hard_rst | ~run_r),
        .sel     (cks_r),
        .tick    (tick)
    );

    // ======================================================
    // pin reset synchroniser
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= external_reset_pin_n;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ======================================================
    // counter and control register
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            count_r   <= CNT_ZERO;
            ovf_r     <= 1'b0;
            mode_r    <= 1'b0;
            run_r     <= 1'b0;
            cks_r     <= 3'h0;
            ovf_arm_r <= 1'b0;
        end else if (wd_evt) begin
            // watchdog overflow resets the timer's own registers
            count_r   <= CNT_ZERO;
            ovf_r     <= 1'b0;
            mode_r    <= 1'b0;
            run_r     <= 1'b0;
            cks_r     <= 3'h0;
            ovf_arm_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            if (wr_ctl) begin
                mode_r <= wdat[CTL_MODE_BIT];
                run_r  <= wdat[CTL_RUN_BIT];
                cks_r  <= wdat[CTL_CKS_LSB +: 3];
            end
            // set wins over a coinciding clear
            ovf_r <= it_evt | (ovf_r & ~ovf_clr);
            if (ovf_clr || it_evt) begin
                ovf_arm_r <= 1'b0;
            end else if (rd_ctl && ovf_r) begin
                ovf_arm_r <= 1'b1;
            end
        end
    end

    // ======================================================
    // reset control register; survives the internal reset
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            wdflag_r     <= 1'b0;
            rgen_r       <= 1'b0;
            rtype_r      <= 1'b0;
            wdflag_arm_r <= 1'b0;
        end else begin
            wdflag_r <= wd_evt | (wdflag_r & ~wd_clr);
            if (wr_rbits) begin
                rgen_r  <= wdat[RST_RGEN_BIT];
                rtype_r <= wdat[RST_TYPE_BIT];
            end
            // a read while the output is low does not count
            if (wd_clr || wd_evt) begin
                wdflag_arm_r <= 1'b0;
            end else if (rd_rst && wdflag_r && !out_low_r) begin
                wdflag_arm_r <= 1'b1;
            end
        end
    end

    // ======================================================
    // overflow output and internal reset pulse
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            out_low_r  <= 1'b0;
            out_cnt_r  <= 8'h00;
            out_rgen_r <= 1'b0;
            irst_r     <= 1'b0;
            irst_man_r <= 1'b0;
            irst_cnt_r <= 10'h000;
        end else begin
            if (wd_evt) begin
                out_low_r  <= 1'b1;
                out_rgen_r <= rgen_r;
                out_cnt_r  <= (rgen_r ? OUT_LEN_RGEN : OUT_LEN_NORST) - 8'h01;
            end else if (out_low_r) begin
                out_low_r <= (out_cnt_r != 8'h00);
                out_cnt_r <= out_cnt_r - 8'h01;
            end
            if (wd_evt && rgen_r) begin
                irst_r     <= 1'b1;
                irst_man_r <= rtype_r;
                irst_cnt_r <= INT_RST_LEN - 10'h001;
            end else if (irst_r) begin
                irst_r     <= (irst_cnt_r != 10'h000);
                irst_cnt_r <= irst_cnt_r - 10'h001;
            end
        end
    end

    // ======================================================
    // read port; unmapped addresses read as zero
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            rdata_r <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_CTRL_RD: rdata_r <= ctl_view;
                ADDR_CNT_RD:  rdata_r <= count_r;
                ADDR_RST_RD:  rdata_r <= rst_view;
                default:      rdata_r <= 8'h00;
            endcase
        end
    end

    assign bus_rdata        = rdata_r;
    assign overflow_out_n   = ~out_low_r;
    assign interval_irq     = ovf_r;
    assign int_reset.active = irst_r;
    assign int_reset.manual = irst_man_r;

    // ======================================================
    // checks
    // ======================================================
    logic [7:0] low_len_r;  // states spent with the output low
    logic [9:0] rst_len_r;  // states spent in internal reset
    always_ff @(posedge ref_clk) begin
        low_len_r <= (hard_rst || !out_low_r) ? 8'h00 : low_len_r + 8'h01;
        rst_len_r <= (hard_rst || !irst_r) ? 10'h000 : rst_len_r + 10'h001;
    end

    wd_flag_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        wd_evt |=> wdflag_r && !overflow_out_n)
        else $error("watchdog overflow did not set flag and output");
    low_len_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        $rose(overflow_out_n) && !$past(hard_rst)
        |-> low_len_r == (out_rgen_r ? OUT_LEN_RGEN : OUT_LEN_NORST))
        else $error("overflow output low for wrong length");
    rst_start_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        wd_evt && rgen_r |=> int_reset.active && !overflow_out_n && int_reset.manual == $past(rtype_r))
        else $error("internal reset not raised with output");
    rst_len_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        $fell(irst_r) && !$past(hard_rst) |-> rst_len_r == INT_RST_LEN)
        else $error("internal reset of wrong length");
    pin_wins_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rst |=> !wdflag_r && !int_reset.active)
        else $error("pin reset did not clear watchdog flag");
    no_rst_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        wd_evt && !rgen_r |=> !int_reset.active && count_r == CNT_ZERO && !run_r)
        else $error("reset disabled overflow misbehaved");
    itv_flag_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        it_evt |=> ovf_r && interval_irq)
        else $error("interval overflow did not raise request");
    wr_skip_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        wr_cnt && tick && run_r |=> count_r == $past(wdat))
        else $error("counter write lost to increment");
    wr_lock_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        !overflow_out_n && bus_req.wr |=> $stable(rgen_r) && $stable(mode_r) && count_r == CNT_ZERO)
        else $error("write accepted while output low");
    halt_zero_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        !run_r |=> count_r == CNT_ZERO)
        else $error("halted counter not zero");
    tick_count_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        run_r && tick && !wr_cnt && count_r != CNT_MAX |=> count_r == $past(count_r) + 8'h01)
        else $error("counter missed a tick");
    itv_quiet_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        it_evt && overflow_out_n && !irst_r |=> overflow_out_n && !int_reset.active && (!wdflag_r || $past(wdflag_r)))
        else $error("interval overflow touched watchdog outputs");
    rd_cnt_a: assert property (@(posedge ref_clk) disable iff (hard_rst)
        bus_req.rd && bus_req.addr == ADDR_CNT_RD |=> bus_rdata == $past(count_r))
        else $error("counter read returned wrong value");
endmodule

// ==== verilog/wit_pkg.sv ====
// ==========================================================
// watchdog / interval timer shared definitions
// ==========================================================
package wit_pkg;

    // ======================================================
    // register addresses (byte addresses of the cpu bus)
    // ======================================================
    localparam logic [15:0] ADDR_CTRL_WR  = 16'hFFBC; // counter / control word-write address
    localparam logic [15:0] ADDR_CTRL_RD  = 16'hFFBC; // timer_control_status read
    localparam logic [15:0] ADDR_CNT_RD   = 16'hFFBD; // timer_counter_value read
    localparam logic [15:0] ADDR_RST_WR   = 16'hFFBE; // reset_control_status word-write address
    localparam logic [15:0] ADDR_RST_RD   = 16'hFFBF; // reset_control_status read

    // ======================================================
    // write keys carried in the upper byte
    // ======================================================
    localparam logic [7:0] KEY_CNT        = 8'h5A; // selects counter, or reset enable/type bits
    localparam logic [7:0] KEY_CTRL       = 8'hA5; // selects control reg, or watchdog flag clear
    localparam logic [7:0] WD_CLR_DATA    = 8'h00; // only data accepted with the clear key

    // ======================================================
    // field positions
    // ======================================================
    localparam int CTL_OVF_BIT  = 7; // interval_overflow_flag
    localparam int CTL_MODE_BIT = 6; // timer_mode_select, 1 = watchdog
    localparam int CTL_RUN_BIT  = 5; // count_run
    localparam int CTL_CKS_LSB  = 0; // clock_divider_select, 3 bits
    localparam int RST_WDFL_BIT = 7; // watchdog_overflow_flag
    localparam int RST_RGEN_BIT = 6; // reset_gen_enable
    localparam int RST_TYPE_BIT = 5; // reset_type_select, 1 = manual

    // ======================================================
    // reset values and read-as-one masks
    // ======================================================
    localparam logic [7:0] CTL_RESERVED   = 8'h18; // bits 4..3 read as one
    localparam logic [7:0] RST_RESERVED   = 8'h1F; // bits 4..0 read as one
    localparam logic [7:0] CNT_MAX        = 8'hFF; // wrap point of the counter
    localparam logic [7:0] CNT_ZERO       = 8'h00;

    // ======================================================
    // timing, in states (one state = one ref_clk cycle)
    // ======================================================
    localparam logic [7:0] OUT_LEN_RGEN   = 8'h84; // overflow_out_n low, reset enabled (132)
    localparam logic [7:0] OUT_LEN_NORST  = 8'h82; // overflow_out_n low, reset disabled (130)
    localparam logic [9:0] INT_RST_LEN    = 10'h206; // internal reset pulse length (518)

    // ======================================================
    // carriers
    // ======================================================
    typedef struct packed {
        logic [15:0] addr;  // byte address
        logic [15:0] wdata; // word write data, key in upper byte
        logic        wr;    // one-cycle word write strobe
        logic        rd;    // one-cycle byte read strobe
    } wit_bus_req_t;

    typedef struct packed {
        logic active; // chip-wide reset requested
        logic manual; // 1 = manual reset, 0 = power-on reset
    } wit_int_rst_t;

    // prescaler tap for each divider select code (divide by 2**n)
    function automatic logic [4:0] wit_tap_shift(input logic [2:0] sel);
        unique case (sel)
            3'h0: wit_tap_shift = 5'd1;
            3'h1: wit_tap_shift = 5'd6;
            3'h2: wit_tap_shift = 5'd7;
            3'h3: wit_tap_shift = 5'd9;
            3'h4: wit_tap_shift = 5'd11;
            3'h5: wit_tap_shift = 5'd13;
            3'h6: wit_tap_shift = 5'd15;
            3'h7: wit_tap_shift = 5'd17;
        endcase
    endfunction

endpackage

// ==== verilog/wit_prescaler.sv ====
`timescale 1ns/1ps
// ==========================================================
// system clock prescaler with selectable tap, held clear while halted
// ==========================================================
module wit_prescaler #(
    parameter int PRE_W = 17 // widest division is 2**17
) (
    input  wire logic       ref_clk,
    input  wire logic       clr,
    input  wire logic [2:0] sel,
    output logic            tick
);
    import wit_pkg::*;

    logic [PRE_W-1:0] pre_r;    // prescaler count
    logic [PRE_W-1:0] pre_nxt;  // next count
    logic [PRE_W-1:0] tap_mask; // low bits that must be zero for a tick
    logic             tick_nxt; // tick for the next cycle
    logic             tick_r;   // registered tick

    // the mask is built from the tap shift, one bit per divide-by-two
    assign tap_mask = PRE_W'((PRE_W+1)'(1) << wit_tap_shift(sel)) - PRE_W'(1);
    assign pre_nxt  = pre_r + PRE_W'(1);
    // one pulse per full period of the chosen tap
    assign tick_nxt = ((pre_nxt & tap_mask) == '0);
    assign tick     = tick_r;

    // ======================================================
    // counter; cleared while the timer is halted so a new
    // run starts from a full period
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            pre_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end
endmodule

// ==== verif/wit_cpu_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// cpu side of the register bus, behavioural
// ==========================================================
module wit_cpu_model (
    input  wire logic             ref_clk,
    output wit_pkg::wit_bus_req_t bus_req,
    input  wire logic [7:0]       bus_rdata
);
    import wit_pkg::*;

    initial bus_req = '0;

    // keyed word write, never a byte write; released lines show garbage
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // byte read, data taken once the strobe edge has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
        #1;
        d = bus_rdata;
    endtask
endmodule

// ==== verif/wit_timer_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the watchdog / interval timer
// ==========================================================
module wit_timer_tb_top;
    import wit_pkg::*;

    logic          ref_clk = 0;
    logic          sys_rst = 1;
    logic          pin_n   = 1; // external pin, never fed from the overflow output
    logic [7:0]    rdata;
    logic [7:0]    v;
    logic          ovf_n;
    logic          irq;
    wit_int_rst_t  irst;
    wit_bus_req_t  req;
    logic [15:0]   lfsr    = 16'h56F7; // seed 22263
    int            miscompares = 0;
    int            compares    = 0;
    int            lo_run = 0, lo_len = 0, rs_run = 0, rs_len = 0, falls = 0;

    always #10 ref_clk = ~ref_clk;

    wit_timer #(.PRE_W(17)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .external_reset_pin_n(pin_n),
        .bus_req(req), .bus_rdata(rdata), .overflow_out_n(ovf_n), .interval_irq(irq), .int_reset(irst));
    wit_cpu_model cpu (.ref_clk(ref_clk), .bus_req(req), .bus_rdata(rdata));

    // ======================================================
    // pulse lengths measured at the pins, in states
    // ======================================================
    always @(posedge ref_clk) begin
        if (ovf_n === 1'b0) begin
            lo_run <= lo_run + 1;
        end else if (lo_run != 0) begin
            lo_len <= lo_run;
            lo_run <= 0;
            falls  <= falls + 1;
        end
        if (irst.active === 1'b1) begin
            rs_run <= rs_run + 1;
        end else if (rs_run != 0) begin
            rs_len <= rs_run;
            rs_run <= 0;
        end
    end

    // ======================================================
    // expectations and helpers
    // ======================================================
    function automatic logic [7:0] ctl_exp(input logic o, m, r, input logic [2:0] c);
        return {o, m, r, 2'b11, c};
    endfunction
    function automatic logic [7:0] rst_exp(input logic w, e, s);
        return {w, e, s, 5'h1F};
    endfunction
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string n);
        cpu.rd(a, v);
        chk(n, {2'b00, e}, {2'b00, v});
    endtask
    // bounded wait: 0 output low, 1 irq high, 2 output and reset released
    // a limit that runs out is counted as a mismatch
    task automatic wait_for(input int sel, input int lim);
        bit hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge ref_clk);
            #1;
            hit = (sel == 0 && ovf_n === 1'b0) || (sel == 1 && irq === 1'b1)
                  || (sel == 2 && ovf_n === 1'b1 && irst.active === 1'b0);
        end
        chk("wait", 10'd1, {9'd0, hit});
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watchdog run: kicks first, then a forced overflow
    task automatic wd_run(input logic e, input logic s);
        int f;
        cpu.wr(ADDR_RST_WR, {KEY_CNT, 1'b0, e, s, 5'h00});
        cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 1, 1, 0)});
        f = falls;
        repeat (3) begin
            repeat (300) @(posedge ref_clk);
            cpu.wr(ADDR_CTRL_WR, {KEY_CNT, CNT_ZERO});
        end
        chk("kicked", f, falls);
        cpu.wr(ADDR_CTRL_WR, {KEY_CNT, 8'hFE});
        wait_for(0, 40);
        chk("int_reset", {e, s}, {irst.active, irst.manual});
        cpu.wr(ADDR_RST_WR, {KEY_CNT, 8'h00});
        rd_chk(ADDR_RST_RD, rst_exp(1, e, s), "flag set");
        wait_for(2, 600);
        repeat (2) @(posedge ref_clk);
        chk("low len", e ? 10'd132 : 10'd130, lo_len);
        chk("rst len", e ? 10'd518 : 10'd0, rs_len);
        rd_chk(ADDR_CTRL_RD, ctl_exp(0, 0, 0, 0), "ctl reset");
        rd_chk(ADDR_CNT_RD, CNT_ZERO, "cnt reset");
        cpu.wr(ADDR_RST_WR, {KEY_CTRL, WD_CLR_DATA});
        rd_chk(ADDR_RST_RD, rst_exp(1, e, s), "unarmed");
        cpu.wr(ADDR_RST_WR, {KEY_CTRL, WD_CLR_DATA});
        rd_chk(ADDR_RST_RD, rst_exp(0, e, s), "cleared");
    endtask

    // ======================================================
    // main sequence
    // ======================================================
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk(ADDR_CTRL_RD, 8'h18, "ctl init");
        rd_chk(ADDR_CNT_RD, 8'h00, "cnt init");
        rd_chk(ADDR_RST_RD, 8'h1F, "rst init");
        rd_chk(16'hFFBB, 8'h00, "unmapped");
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 0, 0, lfsr[10:8])});
            cpu.wr(ADDR_CTRL_WR, {KEY_CNT, lfsr[7:0]});
            rd_chk(ADDR_CNT_RD, CNT_ZERO, "halted");
            rd_chk(ADDR_CTRL_RD, ctl_exp(0, 0, 0, lfsr[10:8]), "divider");
            // odd passes count on the divide-by-64 tap, even ones on divide-by-2
            cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 0, 0, {2'b00, k[0]})});
            cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 0, 1, {2'b00, k[0]})});
            cpu.wr(ADDR_CTRL_WR, {KEY_CNT, lfsr[7:0] | 8'hC0});
            wait_for(1, 4400);
            chk("irq", 1, irq);
            chk("no wdg", 2'b10, {ovf_n, irst.active});
            rd_chk(ADDR_CTRL_RD, ctl_exp(1, 0, 1, {2'b00, k[0]}), "ovf 1");
            rd_chk(ADDR_CTRL_RD, ctl_exp(1, 0, 1, {2'b00, k[0]}), "ovf 2");
            cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 0, 1, {2'b00, k[0]})});
            @(posedge ref_clk);
            #1;
            chk("irq clr", 0, irq);
            cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 0, 0, {2'b00, k[0]})});
        end
        wd_run(1'b0, 1'b0);
        wd_run(1'b1, 1'b1);
        cpu.wr(ADDR_RST_WR, {KEY_CNT, 8'h40});
        cpu.wr(ADDR_CTRL_WR, {KEY_CTRL, ctl_exp(0, 1, 1, 0)});
        cpu.wr(ADDR_CTRL_WR, {KEY_CNT, 8'hFF});
        pin_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pin_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd_chk(ADDR_RST_RD, 8'h1F, "pin wins");
        report_and_stop();
    end

    // hang guard, about four times the expected run of some 5000 cycles
    initial begin
        #400us;
        miscompares++;
        report_and_stop();
    end
endmodule
